/* srs_sequencer.sv */
// Reset and bus-clock sequencer with its AHB-Lite register slave.
// Assumes i_core_clk is the oscillator reference; the PLL clock arrives as
// a same-domain tick; the reset pin and watchdog request are asynchronous.
//
// Behaviour
// - bus clock tick is oscillator or PLL tick divided by four.
// - power-on or low voltage holds clocks off 4096 cycles, pin low.
// - stop exit waits 4096 or 32 counter cycles before clocks resume.
// - wait mode stops CPU ticks, peripheral ticks keep running.
// - every reset asserts internal reset and presents the reset vector.
// - internal reset returns all registers except the reset cause register to default values.
// - internal sources clear the system counter; the pin does not.
// - each reset source sets its own cause bit.
// - reset aborts at once and selects oscillator divided by four.
// - reset pin held low halts all processing while low.
// - pin cause set after 4163 or 67 low cycles, no other source.
// - internal reset drives pin 32 cycles, holds reset 32 more.
// - power-on or low voltage first counts 4096 with pin low.
// - watchdog request is synchronised, no clock alignment assumed.
// - power-on holds pin for 4096 plus 32, releases 32 later.
// - power-on pulse asserts internal reset, enables clock generator.
// - power-on sets the power-on cause bit.
// - system counter is twelve bits; overflow clocks the watchdog.
// - short stop recovery option selects 32 instead of 4096 cycles.
`timescale 1ns/10ps

module srs_sequencer #(
	parameter int P_PIN_POR_CYC = srs_pkg::PIN_POR_CYC
) (
	input  wire logic              i_core_clk,         // Oscillator reference
	input  wire logic              i_rst,              // Async reset, high
	// AHB-Lite slave
	input  wire logic              hsel,               // Slave select
	input  wire logic [31:0]       haddr,              // Byte address
	input  wire logic [1:0]        htrans,             // Transfer type
	input  wire logic              hwrite,             // Write when high
	input  wire logic [2:0]        hsize,              // Word only
	input  wire logic [31:0]       hwdata,             // Write data
	input  wire logic              hready,             // Bus ready
	output logic                   hreadyout,          // Always ready
	output logic [31:0]            hrdata,             // Read data
	output logic                   hresp,              // Always OKAY
	// Reset sources and pin
	input  wire srs_pkg::srs_src_t i_src,              // Synchronous sources
	input  wire logic              i_watchdog_timeout, // Async request
	input  wire logic              i_rst_pin_n,        // Pin level in
	output logic                   o_rst_pin_o,        // Pin drive value
	output logic                   o_rst_pin_oe,       // Pin drive enable
	// Core side
	input  wire logic              i_monitor_mode,     // Monitor vector
	input  wire logic              i_pll_clock_tick,   // PLL rate tick
	input  wire logic              i_stop_req,         // Enter stop, pulse
	input  wire logic              i_wait_req,         // Enter wait, pulse
	input  wire logic              i_wake,             // Interrupt wake
	input  wire logic [19:0]       i_irq_pending,      // Pending sources
	output logic                   o_internal_reset,   // Module reset
	output logic                   o_vector_fetch,     // Vector fetch pulse
	output logic [15:0]            o_reset_vector,     // Vector address
	output srs_pkg::srs_clk_t      o_clk,              // Clock enables
	output logic                   o_cop_clk,          // Counter overflow
	output logic                   o_break_flag_clear_enable // Break control
);

	// ----------------------------------------------------------------
	// Synchronisers
	// ----------------------------------------------------------------
	logic [1:0] pin_sync;
	logic [1:0] cop_sync;
	logic       pin_low;
	logic       cop_req;

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			pin_sync <= 2'h3;
			cop_sync <= 2'h0;
		end else begin
			pin_sync <= {pin_sync[0], i_rst_pin_n};
			cop_sync <= {cop_sync[0], i_watchdog_timeout};
		end
	end

	assign pin_low = ~pin_sync[1];
	assign cop_req = cop_sync[1];

	// ----------------------------------------------------------------
	// Source decode
	// ----------------------------------------------------------------
	logic any_int;
	logic por_lvi;

	assign por_lvi = i_src.power_on_pulse | i_src.low_voltage_detector;
	assign any_int = por_lvi | i_src.illegal_opcode | i_src.illegal_address
		| i_src.monitor_entry_reset | cop_req;

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	srs_pkg::srs_state_t state;
	srs_pkg::srs_state_t next_state;
	logic [12:0]         seq_cnt;
	logic [12:0]         next_seq_cnt;
	logic                por_path;
	logic                next_por_path;
	logic                vec_pulse;
	logic                next_vec_pulse;
	logic [11:0]         sys_cnt;
	logic [11:0]         next_sys_cnt;
	logic                cop_tick;
	logic                next_cop_tick;
	logic                stop_short;

	always_comb begin
		next_state     = state;
		next_seq_cnt   = seq_cnt + 13'h0001;
		next_por_path  = por_path;
		next_vec_pulse = 1'b0;
		if (any_int) begin
			// Aborts whatever runs, from any state
			next_state    = por_lvi ? srs_pkg::ST_POR_WAIT : srs_pkg::ST_PIN_LOW;
			next_seq_cnt  = 13'h0000;
			next_por_path = por_path | por_lvi;
		end else begin
			unique case (state)
				srs_pkg::ST_POR_WAIT: begin
					if (seq_cnt == srs_pkg::POR_WAIT_CYC - 13'h0001) begin
						next_state   = srs_pkg::ST_PIN_LOW;
						next_seq_cnt = 13'h0000;
					end
				end
				srs_pkg::ST_PIN_LOW: begin
					if (seq_cnt == srs_pkg::PIN_DRIVE_CYC - 13'h0001) begin
						next_state   = srs_pkg::ST_INTERNAL_RESET_HOLD;
						next_seq_cnt = 13'h0000;
					end
				end
				srs_pkg::ST_INTERNAL_RESET_HOLD: begin
					// Own drive still visible through the synchroniser early on
					if (pin_low && seq_cnt >= srs_pkg::PIN_MASK_CYC) begin
						next_state = srs_pkg::ST_EXT_HOLD;
					end else if (seq_cnt == srs_pkg::INTERNAL_RESET_HOLD_CYC - 13'h0001) begin
						next_state     = srs_pkg::ST_RUN;
						next_vec_pulse = 1'b1;
						next_por_path  = 1'b0;
					end
				end
				srs_pkg::ST_EXT_HOLD: begin
					if (!pin_low) begin
						next_state   = srs_pkg::ST_INTERNAL_RESET_HOLD;
						next_seq_cnt = srs_pkg::PIN_MASK_CYC;
					end
				end
				srs_pkg::ST_RUN: begin
					if (pin_low) begin
						next_state = srs_pkg::ST_EXT_HOLD;
					end else if (i_stop_req) begin
						next_state = srs_pkg::ST_STOP;
					end else if (i_wait_req) begin
						next_state = srs_pkg::ST_WAIT;
					end
				end
				srs_pkg::ST_WAIT: begin
					if (pin_low) begin
						next_state = srs_pkg::ST_EXT_HOLD;
					end else if (i_wake) begin
						next_state = srs_pkg::ST_RUN;
					end
				end
				srs_pkg::ST_STOP: begin
					if (pin_low) begin
						next_state = srs_pkg::ST_EXT_HOLD;
					end else if (i_wake) begin
						next_state = srs_pkg::ST_STOP_REC;
					end
				end
				srs_pkg::ST_STOP_REC: begin
					if (pin_low) begin
						next_state = srs_pkg::ST_EXT_HOLD;
					end else if (sys_cnt == (stop_short ? srs_pkg::STOP_SHORT_END
							: srs_pkg::STOP_LONG_END)) begin
						next_state = srs_pkg::ST_RUN;
					end
				end
			endcase
		end
	end

	// System counter: free running, cleared by internal sources, stop entry and wake from stop
	always_comb begin
		next_sys_cnt  = sys_cnt + 12'h001;
		next_cop_tick = (sys_cnt == 12'hFFF);
		if (any_int) begin
			next_sys_cnt  = 12'h000;
			next_cop_tick = 1'b0;
		end else if (state == srs_pkg::ST_RUN && i_stop_req) begin
			next_sys_cnt = 12'h000;
		end else if (state == srs_pkg::ST_STOP && next_state == srs_pkg::ST_STOP_REC) begin
			// Recovery delay counts from the wake, not from stop entry
			next_sys_cnt = 12'h000;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			state     <= srs_pkg::ST_POR_WAIT;
			seq_cnt   <= 13'h0000;
			por_path  <= 1'b1;
			vec_pulse <= 1'b0;
			sys_cnt   <= 12'h000;
			cop_tick  <= 1'b0;
		end else begin
			state     <= next_state;
			seq_cnt   <= next_seq_cnt;
			por_path  <= next_por_path;
			vec_pulse <= next_vec_pulse;
			sys_cnt   <= next_sys_cnt;
			cop_tick  <= next_cop_tick;
		end
	end

	logic in_reset;
	assign in_reset = (state == srs_pkg::ST_POR_WAIT) || (state == srs_pkg::ST_PIN_LOW)
		|| (state == srs_pkg::ST_INTERNAL_RESET_HOLD) || (state == srs_pkg::ST_EXT_HOLD);

	// ----------------------------------------------------------------
	// Pin low measurement
	// ----------------------------------------------------------------
	logic [12:0] pin_cnt;
	logic [12:0] next_pin_cnt;
	logic        other_seen;
	logic        next_other_seen;
	logic        pin_cause;
	logic [12:0] pin_need;

	assign pin_need = por_path ? P_PIN_POR_CYC[12:0] : srs_pkg::PIN_MIN_CYC;

	always_comb begin
		next_pin_cnt    = pin_cnt;
		next_other_seen = other_seen;
		if (!pin_low) begin
			next_pin_cnt    = 13'h0000;
			next_other_seen = 1'b0;
		end else begin
			if (pin_cnt != 13'h1FFF) begin
				next_pin_cnt = pin_cnt + 13'h0001;
			end
			if (any_int && state == srs_pkg::ST_EXT_HOLD) begin
				next_other_seen = 1'b1;
			end
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			pin_cnt    <= 13'h0000;
			other_seen <= 1'b0;
		end else begin
			pin_cnt    <= next_pin_cnt;
			other_seen <= next_other_seen;
		end
	end

	// Judged on release of an externally held pin
	assign pin_cause = (state == srs_pkg::ST_EXT_HOLD) && !pin_low && !any_int
		&& (pin_cnt >= pin_need) && !other_seen;

	// ----------------------------------------------------------------
	// AHB-Lite slave
	// ----------------------------------------------------------------
	logic        wr_pend;
	logic        next_wr_pend;
	logic [15:0] wr_idx;
	logic [15:0] next_wr_idx;
	logic [31:0] next_hrdata;
	logic        acc;
	logic        wr_go;

	logic [7:0]  cause;
	logic [7:0]  next_cause;
	logic [7:0]  ctrl;
	logic [7:0]  next_ctrl;
	logic [7:0]  bfc;
	logic [7:0]  next_bfc;
	logic [19:0] irq_flag;
	logic        gen_en;
	logic        next_gen_en;

	function automatic logic [7:0] reg_read(input logic [15:0] idx);
		unique case (idx)
			srs_pkg::IDX_RESET_CAUSE: reg_read = cause;
			srs_pkg::IDX_CLOCK_CTRL:  reg_read = ctrl;
			srs_pkg::IDX_BREAK_FLAG:  reg_read = bfc;
			srs_pkg::IDX_IRQ_ONE:     reg_read = {irq_flag[5:0], 2'h0};
			srs_pkg::IDX_IRQ_TWO:     reg_read = irq_flag[13:6];
			srs_pkg::IDX_IRQ_THREE:   reg_read = {2'h0, irq_flag[19:14]};
			default:                  reg_read = 8'h00;
		endcase
	endfunction

	assign acc   = hsel && hready && htrans[1];
	assign wr_go = wr_pend && hready;

	always_comb begin
		next_wr_pend = wr_pend;
		next_wr_idx  = wr_idx;
		next_hrdata  = hrdata;
		if (hready) begin
			next_wr_pend = acc && hwrite;
			next_wr_idx  = haddr[17:2];
			if (acc && !hwrite) begin
				next_hrdata = {24'h000000, reg_read(haddr[17:2])};
			end
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			wr_pend <= 1'b0;
			wr_idx  <= 16'h0000;
			hrdata  <= 32'h00000000;
		end else begin
			wr_pend <= next_wr_pend;
			wr_idx  <= next_wr_idx;
			hrdata  <= next_hrdata;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_comb begin
		next_cause = cause;
		next_ctrl  = ctrl;
		next_bfc   = bfc;
		if (wr_go && wr_idx == srs_pkg::IDX_RESET_CAUSE) begin
			next_cause = cause & ~hwdata[7:0];
		end
		if (wr_go && wr_idx == srs_pkg::IDX_CLOCK_CTRL) begin
			next_ctrl = {6'h00, hwdata[srs_pkg::CTRL_SSR], hwdata[srs_pkg::CTRL_PLL_SEL]};
		end
		if (wr_go && wr_idx == srs_pkg::IDX_BREAK_FLAG) begin
			next_bfc = {hwdata[srs_pkg::BFC_CLR_EN], 7'h00};
		end
		// Sets after clears so an event in a clearing write is kept
		if (i_src.power_on_pulse) begin
			next_cause = 8'h00;
			next_cause[srs_pkg::CAUSE_POR] = 1'b1;
		end
		next_cause[srs_pkg::CAUSE_LVI]    = next_cause[srs_pkg::CAUSE_LVI]
			| i_src.low_voltage_detector;
		next_cause[srs_pkg::CAUSE_COP]    = next_cause[srs_pkg::CAUSE_COP] | cop_req;
		next_cause[srs_pkg::CAUSE_ILOP]   = next_cause[srs_pkg::CAUSE_ILOP]
			| i_src.illegal_opcode;
		next_cause[srs_pkg::CAUSE_ILAD]   = next_cause[srs_pkg::CAUSE_ILAD]
			| i_src.illegal_address;
		next_cause[srs_pkg::CAUSE_MONITOR_ENTRY_RESET] = next_cause[srs_pkg::CAUSE_MONITOR_ENTRY_RESET]
			| i_src.monitor_entry_reset;
		next_cause[srs_pkg::CAUSE_PIN]    = next_cause[srs_pkg::CAUSE_PIN] | pin_cause;
		// Internal reset restores defaults; cause history survives it
		if (in_reset) begin
			next_ctrl = srs_pkg::REG8_RESET;
			next_bfc  = srs_pkg::REG8_RESET;
		end
		next_gen_en = gen_en | i_src.power_on_pulse;
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			cause    <= srs_pkg::CAUSE_RESET;
			ctrl     <= srs_pkg::REG8_RESET;
			bfc      <= srs_pkg::REG8_RESET;
			irq_flag <= 20'h00000;
			gen_en   <= 1'b0;
		end else begin
			cause    <= next_cause;
			ctrl     <= next_ctrl;
			bfc      <= next_bfc;
			irq_flag <= in_reset ? 20'h00000 : i_irq_pending;
			gen_en   <= next_gen_en;
		end
	end

	assign stop_short = ctrl[srs_pkg::CTRL_SSR];

	// ----------------------------------------------------------------
	// Bus clock divider and gating
	// ----------------------------------------------------------------
	logic [1:0] div_cnt;
	logic [1:0] next_div_cnt;
	logic       src_tick;
	logic       bus_tick;
	srs_pkg::srs_clk_t next_clk;

	// PLL source only when selected; reset forces the oscillator
	assign src_tick = ctrl[srs_pkg::CTRL_PLL_SEL] ? i_pll_clock_tick : 1'b1;
	assign bus_tick = src_tick && (div_cnt == srs_pkg::BUS_DIV_END) && gen_en;

	always_comb begin
		next_div_cnt = src_tick ? div_cnt + 2'h1 : div_cnt;
		next_clk.clock_gen_out = next_gen_en;
		next_clk.pll_selected  = ctrl[srs_pkg::CTRL_PLL_SEL];
		// Gated by the next state so no tick leaks into a reset cycle
		next_clk.cpu_tick      = bus_tick && (next_state == srs_pkg::ST_RUN);
		next_clk.periph_tick   = bus_tick && ((next_state == srs_pkg::ST_RUN)
			|| (next_state == srs_pkg::ST_WAIT));
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			div_cnt <= 2'h0;
			o_clk   <= '0;
		end else begin
			div_cnt <= next_div_cnt;
			o_clk   <= next_clk;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	logic pin_drive;
	assign pin_drive = (state == srs_pkg::ST_POR_WAIT) || (state == srs_pkg::ST_PIN_LOW);

	assign o_rst_pin_o      = 1'b0;
	assign o_rst_pin_oe     = pin_drive;
	assign o_internal_reset = in_reset;
	assign o_vector_fetch   = vec_pulse;
	assign o_reset_vector   = i_monitor_mode ? srs_pkg::VEC_MONITOR : srs_pkg::VEC_USER;
	assign o_cop_clk        = cop_tick;
	assign o_break_flag_clear_enable = bfc[srs_pkg::BFC_CLR_EN];

endmodule

/* srs_pkg.sv */
// Package for the reset and bus-clock sequencer: register map, fields,
// timing counts, state codes and carrier structs.
// Assumes the core clock is the oscillator reference at 125 MHz.
package srs_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address = 4 * index)
	// ----------------------------------------------------------------
	localparam logic [15:0] IDX_RESET_CAUSE   = 16'hFE01;
	localparam logic [15:0] IDX_CLOCK_CTRL    = 16'hFE02;
	localparam logic [15:0] IDX_BREAK_FLAG    = 16'hFE03;
	localparam logic [15:0] IDX_IRQ_ONE       = 16'hFE04;
	localparam logic [15:0] IDX_IRQ_TWO       = 16'hFE05;
	localparam logic [15:0] IDX_IRQ_THREE     = 16'hFE06;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int CAUSE_POR     = 7;
	localparam int CAUSE_PIN     = 6;
	localparam int CAUSE_COP     = 5;
	localparam int CAUSE_ILOP    = 4;
	localparam int CAUSE_ILAD    = 3;
	localparam int CAUSE_MONITOR_ENTRY_RESET  = 2;
	localparam int CAUSE_LVI     = 1;
	localparam int CTRL_PLL_SEL  = 0;
	localparam int CTRL_SSR      = 1;
	localparam int BFC_CLR_EN    = 7;
	localparam logic [7:0] CAUSE_RESET = 8'h00;
	localparam logic [7:0] REG8_RESET  = 8'h00;

	// ----------------------------------------------------------------
	// Timing in oscillator reference cycles
	// ----------------------------------------------------------------
	localparam logic [12:0] POR_WAIT_CYC   = 13'h1000; // 4096
	localparam logic [12:0] PIN_DRIVE_CYC  = 13'h0020; // 32
	localparam logic [12:0] INTERNAL_RESET_HOLD_CYC  = 13'h0020; // 32
	localparam logic [12:0] PIN_MASK_CYC   = 13'h0003; // Sync lag after own drive
	localparam logic [12:0] PIN_MIN_CYC    = 13'h0043; // 67
	localparam int          PIN_POR_CYC    = 4163;
	localparam logic [11:0] STOP_LONG_END  = 12'hFFF;  // 4096 cycles
	localparam logic [11:0] STOP_SHORT_END = 12'h01F;  // 32 cycles
	localparam logic [1:0]  BUS_DIV_END    = 2'h3;     // Divide by four
	localparam logic [15:0] VEC_USER       = 16'hFFFE;
	localparam logic [15:0] VEC_MONITOR    = 16'hFEFE;

	// ----------------------------------------------------------------
	// Sequencer states, Gray along reset -> run -> stop
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_POR_WAIT  = 3'h0,
		ST_PIN_LOW   = 3'h1,
		ST_INTERNAL_RESET_HOLD = 3'h3,
		ST_RUN       = 3'h2,
		ST_STOP      = 3'h6,
		ST_STOP_REC  = 3'h7,
		ST_WAIT      = 3'h5,
		ST_EXT_HOLD  = 3'h4
	} srs_state_t;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic power_on_pulse;
		logic low_voltage_detector;
		logic illegal_opcode;
		logic illegal_address;
		logic monitor_entry_reset;
	} srs_src_t;

	typedef struct packed {
		logic clock_gen_out;
		logic cpu_tick;
		logic periph_tick;
		logic pll_selected;
	} srs_clk_t;

endpackage

/* srs_seq_sva.sv */
// Checker for the reset sequencer, bound to its top module.
// Assumes one clock domain, reset by i_rst.
`timescale 1ns/10ps

module srs_seq_sva #(
	parameter int P_PIN_POR_CYC = 4163
) (
	input wire logic              i_core_clk,       // Reference clock
	input wire logic              i_rst,            // Async reset
	input wire srs_pkg::srs_src_t i_src,            // Reset sources
	input wire logic              i_rst_pin_n,      // Pin level
	input wire logic              i_monitor_mode,   // Monitor select
	input wire logic              o_rst_pin_o,      // Pin value
	input wire logic              o_rst_pin_oe,     // Pin enable
	input wire logic              o_internal_reset, // Module reset
	input wire logic              o_vector_fetch,   // Vector pulse
	input wire logic [15:0]       o_reset_vector,   // Vector address
	input wire srs_pkg::srs_clk_t o_clk,            // Clock enables
	input wire logic              o_cop_clk         // Overflow pulse
);
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	property p_src_oe;
		(|i_src) |=> o_rst_pin_oe;
	endproperty
	a_src_oe: assert property (p_src_oe) else $error("pin not driven after source");

	property p_oe_internal_reset;
		o_rst_pin_oe |-> (o_internal_reset && !o_rst_pin_o);
	endproperty
	a_oe_internal_reset: assert property (p_oe_internal_reset) else $error("pin drive without reset");

	property p_quiet;
		o_internal_reset |-> !(o_clk.cpu_tick || o_clk.periph_tick);
	endproperty
	a_quiet: assert property (p_quiet) else $error("clock tick during reset");

	property p_vec;
		o_vector_fetch |-> o_reset_vector ==
			(i_monitor_mode ? srs_pkg::VEC_MONITOR : srs_pkg::VEC_USER);
	endproperty
	a_vec: assert property (p_vec) else $error("wrong reset vector");

	property p_hold;
		$fell(o_rst_pin_oe) |-> o_internal_reset ##[31:33] o_vector_fetch;
	endproperty
	a_hold: assert property (p_hold) else $error("reset hold length wrong");

	property p_div;
		o_clk.cpu_tick |=> !o_clk.cpu_tick [*3];
	endproperty
	a_div: assert property (p_div) else $error("bus tick faster than quarter");

	property p_pin;
		$fell(i_rst_pin_n) |-> ##[1:4] o_internal_reset;
	endproperty
	a_pin: assert property (p_pin) else $error("pin low did not halt");

	property p_cop;
		o_cop_clk |=> !o_cop_clk [*8];
	endproperty
	a_cop: assert property (p_cop) else $error("overflow pulses too close");

	c_vec: cover property (o_vector_fetch && i_monitor_mode);
	c_cop: cover property (o_cop_clk);
	c_pin: cover property ($fell(i_rst_pin_n) && !o_rst_pin_oe);
endmodule

/* srs_pin_model.sv */
// Reset pin partner: pulled-up wire shared by device and outside party.
// Assumes the device only pulls low; the bench commands outside pulls.
`timescale 1ns/10ps

module srs_pin_model (
	input  wire logic i_dev_o,   // Device drive value
	input  wire logic i_dev_oe,  // Device drive enable
	input  wire logic i_ext_low, // Outside party pulls low
	output logic      o_pin_n    // Resolved pin level
);
	// Pull-up wins when nobody drives, so a released pin reads high
	assign o_pin_n = ~((i_dev_oe & ~i_dev_o) | i_ext_low);
endmodule

/* testbench.sv */
// Testbench for the reset sequencer: AHB-Lite master, sources, pin.
// Assumes package, sequencer, pin model and checker compiled first.
`timescale 1ns/10ps

module testbench;
	localparam int         P_PIN_POR_CYC = 100;
	localparam logic [19:0] PEND          = 20'hA5C3E;
	logic                  i_core_clk, i_rst, hsel, hwrite, hreadyout, hresp;
	logic [31:0]           haddr, hwdata, hrdata, rd_q;
	logic [1:0]            htrans;
	srs_pkg::srs_src_t     i_src;
	logic                  i_watchdog_timeout, rst_pin_n, o_rst_pin_o, o_rst_pin_oe;
	logic                  ext_low, i_monitor_mode, i_pll_clock_tick, i_stop_req;
	logic                  i_wait_req, i_wake, o_internal_reset, o_vector_fetch, o_cop_clk;
	logic [19:0]           i_irq_pending;
	logic [15:0]           o_reset_vector;
	srs_pkg::srs_clk_t     o_clk;
	int                    fails, checks;

	srs_sequencer #(.P_PIN_POR_CYC(P_PIN_POR_CYC)) dut (.i_core_clk, .i_rst, .hsel, .haddr,
		.htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata,
		.hresp, .i_src, .i_watchdog_timeout, .i_rst_pin_n(rst_pin_n), .o_rst_pin_o,
		.o_rst_pin_oe, .i_monitor_mode, .i_pll_clock_tick, .i_stop_req, .i_wait_req,
		.i_wake, .i_irq_pending, .o_internal_reset, .o_vector_fetch, .o_reset_vector,
		.o_clk, .o_cop_clk, .o_break_flag_clear_enable());
	srs_pin_model pin (.i_dev_o(o_rst_pin_o), .i_dev_oe(o_rst_pin_oe), .i_ext_low(ext_low),
		.o_pin_n(rst_pin_n));

	initial begin
		i_core_clk = 1'b0;
		forever #4 i_core_clk = ~i_core_clk;
	end
	// PLL rate tick at half the reference, so PLL bus ticks come every 8
	always @(posedge i_core_clk) i_pll_clock_tick <= ~i_pll_clock_tick;
	always @(posedge i_core_clk) rd_q <= hrdata;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic ahb(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
			output logic [31:0] rd);
		@(posedge i_core_clk);
		hsel   <= 1'b1;
		haddr  <= {14'h0, idx, 2'h0};
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge i_core_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge i_core_clk); while (hreadyout !== 1'b1);
		#1 rd = rd_q;
	endtask

	task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp);
		logic [31:0] v;
		ahb(1'b0, idx, 32'h0, v);
		chk(v, exp);
	endtask

	// 0 wait, 1 stop, 2 wake; one settling edge before returning
	task automatic pulse(input int which);
		@(posedge i_core_clk);
		case (which)
			0: i_wait_req <= 1'b1;
			1: i_stop_req <= 1'b1;
			default: i_wake <= 1'b1;
		endcase
		@(posedge i_core_clk);
		{i_stop_req, i_wait_req, i_wake} <= 3'h0;
		@(posedge i_core_clk);
	endtask

	// Counts are taken on falling edges, clear of the launching edge
	task automatic wait_vec(output int n);
		n = 0;
		while (o_vector_fetch !== 1'b1 && n < 300) begin
			@(negedge i_core_clk);
			n++;
		end
	endtask

	task automatic seq(input int pins, input int hold, input logic [15:0] vec);
		int n;
		n = 0;
		// Watchdog request is seen only after its synchroniser
		while (o_rst_pin_oe !== 1'b1 && n < 8) begin
			@(negedge i_core_clk);
			n++;
		end
		n = 0;
		while (o_rst_pin_oe === 1'b1 && n < 5000) begin
			@(negedge i_core_clk);
			n++;
		end
		chk(32'(n >= pins - 1 && n <= pins + 1), 32'h1);
		wait_vec(n);
		chk(32'(n >= hold - 1 && n <= hold + 1), 32'h1);
		chk(32'(o_reset_vector), 32'(vec));
	endtask

	task automatic fire(input logic [4:0] src, input logic wd);
		@(posedge i_core_clk);
		i_src              <= src;
		i_watchdog_timeout <= wd;
		@(posedge i_core_clk);
		i_src              <= 5'h00;
		i_watchdog_timeout <= 1'b0;
	endtask

	task automatic t_por;
		seq(4128, 32, 16'hFFFE);
		fire(5'h10, 1'b0);
		seq(4128, 32, 16'hFFFE);
		rdchk(srs_pkg::IDX_RESET_CAUSE, 32'h80);
		rdchk(srs_pkg::IDX_IRQ_ONE, 32'h0);
	endtask

	task automatic t_internal;
		logic [31:0] v;
		logic [4:0]  src [5] = '{5'h08, 5'h04, 5'h02, 5'h01, 5'h00};
		logic [7:0]  cause [5] = '{8'h02, 8'h10, 8'h08, 8'h04, 8'h20};
		for (int k = 0; k < 5; k++) begin
			ahb(1'b1, srs_pkg::IDX_RESET_CAUSE, 32'hFF, v);
			ahb(1'b1, srs_pkg::IDX_BREAK_FLAG, 32'h80, v);
			rdchk(srs_pkg::IDX_BREAK_FLAG, 32'h80);
			i_monitor_mode <= (k == 3);
			fire(src[k], k == 4);
			seq(k == 0 ? 4128 : 32, 32, k == 3 ? 16'hFEFE : 16'hFFFE);
			rdchk(srs_pkg::IDX_RESET_CAUSE, 32'(cause[k]));
			rdchk(srs_pkg::IDX_BREAK_FLAG, 32'h0);
		end
		i_monitor_mode <= 1'b0;
	endtask

	task automatic t_pin;
		logic [31:0] v;
		int          n;
		int          lows [2] = '{20, 80};
		for (int k = 0; k < 2; k++) begin
			ahb(1'b1, srs_pkg::IDX_RESET_CAUSE, 32'hFF, v);
			@(posedge i_core_clk);
			ext_low <= 1'b1;
			repeat (lows[k] - 1) @(posedge i_core_clk);
			@(negedge i_core_clk);
			chk(32'(o_internal_reset), 32'h1);
			@(posedge i_core_clk);
			ext_low <= 1'b0;
			wait_vec(n);
			rdchk(srs_pkg::IDX_RESET_CAUSE, k ? 32'h40 : 32'h0);
		end
	endtask

	task automatic t_irq;
		logic [31:0] v;
		i_irq_pending <= PEND;
		rdchk(srs_pkg::IDX_IRQ_ONE, {24'h0, PEND[5:0], 2'h0});
		rdchk(srs_pkg::IDX_IRQ_TWO, {24'h0, PEND[13:6]});
		rdchk(srs_pkg::IDX_IRQ_THREE, {26'h0, PEND[19:14]});
		ahb(1'b1, srs_pkg::IDX_IRQ_ONE, 32'h0, v);
		rdchk(srs_pkg::IDX_IRQ_ONE, {24'h0, PEND[5:0], 2'h0});
		ahb(1'b1, 16'hFE07, 32'hFF, v);
		rdchk(16'hFE07, 32'h0);
		i_irq_pending <= 20'h0;
	endtask

	// Counts bus ticks over a span; n is cycles to the first cpu tick
	task automatic ticks(input int span, output int c, output int p, output int n);
		c = 0;
		p = 0;
		n = span;
		for (int i = 0; i < span; i++) begin
			@(negedge i_core_clk);
			if (o_clk.cpu_tick === 1'b1 && c == 0) n = i;
			c += int'(o_clk.cpu_tick === 1'b1);
			p += int'(o_clk.periph_tick === 1'b1);
		end
	endtask

	task automatic t_modes;
		logic [31:0] v;
		int          c, p, n;
		pulse(0);
		ticks(16, c, p, n);
		chk(32'(c), 32'h0);
		chk(32'(p), 32'h4);
		pulse(2);
		ahb(1'b1, srs_pkg::IDX_CLOCK_CTRL, 32'h02, v);
		pulse(1);
		ticks(40, c, p, n);
		chk(32'(c + p), 32'h0);
		pulse(2);
		ticks(60, c, p, n);
		chk(32'(n >= 28 && n <= 40), 32'h1);
		ahb(1'b1, srs_pkg::IDX_CLOCK_CTRL, 32'h01, v);
		ticks(64, c, p, n);
		chk(32'(c), 32'h8);
	endtask

	task automatic end_of_test;
		if (fails == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		{i_rst, hsel, hwrite, htrans, haddr, hwdata} = {1'b1, 68'h0};
		{i_src, i_watchdog_timeout, ext_low, i_monitor_mode, i_pll_clock_tick} = 9'h0;
		{i_stop_req, i_wait_req, i_wake, i_irq_pending} = 23'h0;
		{fails, checks} = 64'h0;
		repeat (10) @(posedge i_core_clk);
		i_rst <= 1'b0;
		t_por();
		t_internal();
		t_pin();
		t_irq();
		t_modes();
		end_of_test();
	end

	initial begin
		repeat (40000) @(posedge i_core_clk);
		fails++;
		end_of_test();
	end
endmodule

bind srs_sequencer srs_seq_sva #(.P_PIN_POR_CYC(P_PIN_POR_CYC)) u_sva (.i_core_clk, .i_rst,
	.i_src, .i_rst_pin_n, .i_monitor_mode, .o_rst_pin_o, .o_rst_pin_oe, .o_internal_reset,
	.o_vector_fetch, .o_reset_vector, .o_clk, .o_cop_clk);
